// ===== hdl/hsd_top.sv
// hsd_top: shift, predictor range, sine drive and Hall config behind an APB slave
// assumes a synchronous APB master on pclk and Hall inputs synchronous to pclk
//
// Contract
// - shift from pin if select 0, register if 1
// - range 00 predicts 0.8 to 80 Hz
// - range 01 predicts 0.4 to 40 Hz
// - range 1x predicts 3.2 to 320 Hz
// - codes 0..31 map to 0..58 degrees
// - auto mode: sine only when conditions met
// - forced bit enters forced mode unconditionally
// - forced mode: type bit picks square or sine
// - forced sine needs both bits set
// - regulation bit removes glitches, bridges gaps
// - Hall inputs always debounced, 3 to 6 us
// - third Hall input inverted when its bit set
// - second Hall input inverted when its bit set
// - first Hall input inverted when its bit set
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module hsd_top
	import hsd_pkg::*;
#(
	parameter int unsigned CNT_W    = 29,
	parameter int unsigned PER_MIN0 = hsd_pkg::hsd_per_ceil(hsd_pkg::R0_FMAX_MHZ),
	parameter int unsigned PER_MAX0 = hsd_pkg::hsd_per_floor(hsd_pkg::R0_FMIN_MHZ),
	parameter int unsigned PER_MIN1 = PER_MIN0 * (hsd_pkg::R0_FMAX_MHZ / hsd_pkg::R1_FMAX_MHZ),
	parameter int unsigned PER_MAX1 = PER_MAX0 * (hsd_pkg::R0_FMIN_MHZ / hsd_pkg::R1_FMIN_MHZ),
	parameter int unsigned PER_MIN2 = hsd_pkg::hsd_per_ceil(hsd_pkg::R2_FMAX_MHZ),
	parameter int unsigned PER_MAX2 = hsd_pkg::hsd_per_floor(hsd_pkg::R2_FMIN_MHZ)
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  hall_raw,
	input  wire logic [4:0]  external_lead_pin,
	output logic      [4:0]  lead_code,
	output logic      [5:0]  lead_deg,
	output logic             sine_drive,
	output logic             predictor_locked
);
	import hsd_pkg::*;

	if (CNT_W < 8 || CNT_W > 31) begin : g_bad_w
		$error("CNT_W out of range");
	end
	if (PER_MAX0 >= 2**CNT_W || PER_MAX1 >= 2**CNT_W || PER_MAX2 >= 2**CNT_W) begin : g_bad_max
		$error("period limit does not fit CNT_W");
	end
	if (PER_MIN0 < 2 || PER_MIN1 < 2 || PER_MIN2 < 2) begin : g_bad_min
		$error("period minimum too small");
	end
	if (PER_MIN0 > PER_MAX0 || PER_MIN1 > PER_MAX1 || PER_MIN2 > PER_MAX2) begin : g_bad_ord
		$error("period minimum above maximum");
	end

	localparam logic [CNT_W:0] MIN0 = (CNT_W+1)'(PER_MIN0);
	localparam logic [CNT_W:0] MAX0 = (CNT_W+1)'(PER_MAX0);
	localparam logic [CNT_W:0] MIN1 = (CNT_W+1)'(PER_MIN1);
	localparam logic [CNT_W:0] MAX1 = (CNT_W+1)'(PER_MAX1);
	localparam logic [CNT_W:0] MIN2 = (CNT_W+1)'(PER_MIN2);
	localparam logic [CNT_W:0] MAX2 = (CNT_W+1)'(PER_MAX2);

	// scale a lead code to whole degrees, rounded to nearest
	function automatic logic [5:0] lead_scale(input logic [4:0] code);
		logic [11:0] p;
		p = 12'(code) * 12'(LEAD_MAX_DEG) + 12'(LEAD_MAX_CODE / 2);
		return 6'(p / 12'(LEAD_MAX_CODE));
	endfunction : lead_scale

	// ---------------- registers ----------------
	logic [7:0]       shift_control_r;
	logic [7:0]       wave_drive_control_r;
	logic [7:0]       sensor_input_control_r;
	logic [31:0]      prdata_r;
	logic             pready_r;
	logic             pslverr_r;
	logic [4:0]       lead_code_r;
	logic [5:0]       lead_deg_r;
	logic             sine_r;
	logic             locked_r;
	logic             hall0_prev_r;
	logic [CNT_W-1:0] per_cnt_r;
	hsd_pred_e        pst_r;

	hsd_hall_if hall_if ();

	// ---------------- APB decode ----------------
	wire        acc        = psel & penable;
	wire        acc_first  = acc & ~pready_r;
	wire        hit_shift  = (paddr == SHIFT_OFF);
	wire        hit_wave   = (paddr == WAVE_OFF);
	wire        hit_sensor = (paddr == SENSOR_OFF);
	wire        hit_status = (paddr == STATUS_OFF);
	wire        mapped     = hit_shift | hit_wave | hit_sensor | hit_status;
	wire        wr_go      = acc & pready_r & pwrite;

	wire [7:0]  wave_wmask   = 8'hC0;
	wire [7:0]  sensor_wmask = 8'h0F;
	wire [7:0]  status_byte;

	assign status_byte = {3'h0, sine_r, locked_r, hall_if.state};

	wire [31:0] rd_mux = hit_shift  ? {24'h0, shift_control_r} :
	                     hit_wave   ? {24'h0, wave_drive_control_r} :
	                     hit_sensor ? {24'h0, sensor_input_control_r} :
	                     hit_status ? {24'h0, status_byte} : 32'h0;

	// one wait state: data and error are registered in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= acc_first;
			pslverr_r <= acc_first & ~mapped;
			prdata_r  <= (acc_first & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_control_r        <= SHIFT_RST;
			wave_drive_control_r   <= WAVE_RST;
			sensor_input_control_r <= SENSOR_RST;
		end else if (wr_go) begin
			if (hit_shift) shift_control_r <= pwdata[7:0];
			if (hit_wave) wave_drive_control_r <= pwdata[7:0] & wave_wmask;
			if (hit_sensor) sensor_input_control_r <= pwdata[7:0] & sensor_wmask;
		end
	end

	// ---------------- field decode ----------------
	wire       lead_sel            = shift_control_r[SEL_BIT];
	wire [1:0] predictor_speed_range = shift_control_r[RNG_HI:RNG_LO];
	wire [4:0] lead_value          = shift_control_r[ANG_HI:ANG_LO];
	wire       forced_drive_enable = wave_drive_control_r[FORCE_BIT];
	wire       forced_output_type  = wave_drive_control_r[TYPE_BIT];
	wire       hall_regulation_enable = sensor_input_control_r[REG_BIT];
	wire       third_sensor_invert  = sensor_input_control_r[INV3_BIT];
	wire       second_sensor_invert = sensor_input_control_r[INV2_BIT];
	wire       first_sensor_invert  = sensor_input_control_r[INV1_BIT];

	assign hall_if.inv    = {third_sensor_invert, second_sensor_invert, first_sensor_invert};
	assign hall_if.reg_en = hall_regulation_enable;

	hsd_hall_cond u_cond (
		.pclk     (pclk),
		.presetn  (presetn),
		.hall_raw (hall_raw),
		.h        (hall_if.cond)
	);

	// ---------------- lead angle ----------------
	wire [4:0] lead_src = lead_sel ? lead_value : external_lead_pin;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lead_code_r <= 5'h00;
			lead_deg_r  <= 6'h00;
		end else begin
			lead_code_r <= lead_src;
			lead_deg_r  <= lead_scale(lead_code_r);
		end
	end

	// ---------------- position predictor ----------------
	// range 1x ignores the low bit
	wire [CNT_W:0] per_min = predictor_speed_range[1] ? MIN2 :
	                         predictor_speed_range[0] ? MIN1 : MIN0;
	wire [CNT_W:0] per_max = predictor_speed_range[1] ? MAX2 :
	                         predictor_speed_range[0] ? MAX1 : MAX0;
	wire           hall_rise = hall_if.state[0] & ~hall0_prev_r;
	wire [CNT_W:0] per_meas  = {1'b0, per_cnt_r} + (CNT_W+1)'(1);
	wire           in_range  = (per_meas >= per_min) && (per_meas <= per_max);
	wire           too_slow  = ({1'b0, per_cnt_r} >= per_max);

	// period measured between rising edges of the conditioned first input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pst_r        <= P_IDLE;
			per_cnt_r    <= '0;
			locked_r     <= 1'b0;
			hall0_prev_r <= 1'b0;
		end else begin
			hall0_prev_r <= hall_if.state[0];
			case (pst_r)
				P_IDLE: begin
					per_cnt_r <= '0;
					locked_r  <= 1'b0;
					if (hall_rise) pst_r <= P_RUN;
				end
				P_RUN: begin
					if (hall_rise) begin
						per_cnt_r <= '0;
						locked_r  <= in_range;
					end else if (too_slow) begin
						locked_r  <= 1'b0;
						pst_r     <= P_IDLE;
					end else begin
						per_cnt_r <= per_cnt_r + CNT_W'(1);
					end
				end
				default: begin
					pst_r    <= P_IDLE;
					locked_r <= 1'b0;
				end
			endcase
		end
	end

	// ---------------- drive mode ----------------
	// forced mode ignores predictor lock; auto mode waits for it
	wire sine_nxt = forced_drive_enable ? (forced_drive_enable & forced_output_type)
	                                    : locked_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sine_r <= 1'b0;
		end else begin
			sine_r <= sine_nxt;
		end
	end

	assign prdata           = prdata_r;
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign lead_code        = lead_code_r;
	assign lead_deg         = lead_deg_r;
	assign sine_drive       = sine_r;
	assign predictor_locked = locked_r;

	// ---------------- assertions ----------------
	a_lead_source: assert property (@(posedge pclk) disable iff (!presetn)
		(!lead_sel && $stable(external_lead_pin)) |=> ##1 (lead_deg_r == lead_scale($past(external_lead_pin, 2))))
		else $error("lead angle not taken from pin");

	a_lead_scale: assert property (@(posedge pclk) disable iff (!presetn)
		(lead_code_r == 5'h1F) |=> (lead_deg_r == 6'h3A))
		else $error("full lead code does not give 58 degrees");

	a_range_base: assert property (@(posedge pclk) disable iff (!presetn)
		(pst_r == P_RUN && hall_rise && predictor_speed_range == 2'b00
		 && per_meas >= MIN0 && per_meas <= MAX0) |=> locked_r)
		else $error("range 00 did not lock in band");

	a_range_low: assert property (@(posedge pclk) disable iff (!presetn)
		(pst_r == P_RUN && hall_rise && predictor_speed_range == 2'b01
		 && (per_meas < MIN1 || per_meas > MAX1)) |=> !locked_r)
		else $error("range 01 locked out of band");

	a_range_high: assert property (@(posedge pclk) disable iff (!presetn)
		(pst_r == P_RUN && hall_rise && predictor_speed_range[1]
		 && per_meas >= MIN2 && per_meas <= MAX2) |=> locked_r)
		else $error("range 1x did not lock in band");

	a_auto_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(!forced_drive_enable && !locked_r) |=> !sine_r)
		else $error("auto sine without predictor lock");

	a_forced_sine: assert property (@(posedge pclk) disable iff (!presetn)
		(forced_drive_enable && forced_output_type) |=> sine_r)
		else $error("forced sine not entered");

	a_forced_square: assert property (@(posedge pclk) disable iff (!presetn)
		(forced_drive_enable && !forced_output_type) |=> !sine_r)
		else $error("forced square gave sine");

	a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");

	a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_first && !mapped) |=> (pready && pslverr))
		else $error("unmapped access answered without error");

	a_rd_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == 32'h0))
		else $error("read data outside the answer cycle");

	a_wave_mask: assert property (@(posedge pclk) disable iff (!presetn)
		wave_drive_control_r[5:0] == 6'h00)
		else $error("unused wave drive bits set");

	a_sensor_mask: assert property (@(posedge pclk) disable iff (!presetn)
		sensor_input_control_r[7:4] == 4'h0)
		else $error("unused sensor control bits set");

	a_lock_timeout: assert property (@(posedge pclk) disable iff (!presetn)
		(pst_r == P_RUN && !hall_rise && too_slow) |=> (!locked_r && pst_r == P_IDLE))
		else $error("predictor kept lock past the slowest period");

endmodule : hsd_top

// ===== hdl/hsd_pkg.sv
// hsd_pkg: register map, field positions, reset values and timing counts
// assumes a 125 MHz pclk; all cycle counts derive from it
package hsd_pkg;

	// clock
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned CLK_NS     = 8;

	// register byte addresses on the APB
	localparam logic [11:0] SHIFT_OFF  = 12'h000;
	localparam logic [11:0] WAVE_OFF   = 12'h004;
	localparam logic [11:0] SENSOR_OFF = 12'h008;
	localparam logic [11:0] STATUS_OFF = 12'h00C;

	// reset values
	localparam logic [7:0]  SHIFT_RST  = 8'h00;
	localparam logic [7:0]  WAVE_RST   = 8'h00;
	localparam logic [7:0]  SENSOR_RST = 8'h00;

	// shift_control fields
	localparam int unsigned SEL_BIT    = 7;
	localparam int unsigned RNG_HI     = 6;
	localparam int unsigned RNG_LO     = 5;
	localparam int unsigned ANG_HI     = 4;
	localparam int unsigned ANG_LO     = 0;

	// wave_drive_control fields
	localparam int unsigned FORCE_BIT  = 7;
	localparam int unsigned TYPE_BIT   = 6;

	// sensor_input_control fields
	localparam int unsigned REG_BIT    = 3;
	localparam int unsigned INV3_BIT   = 2;
	localparam int unsigned INV2_BIT   = 1;
	localparam int unsigned INV1_BIT   = 0;

	// status fields
	localparam int unsigned ST_HALL_LO = 0;
	localparam int unsigned ST_LOCK    = 3;
	localparam int unsigned ST_SINE    = 4;

	// lead angle scale
	localparam int unsigned LEAD_MAX_CODE = 31;
	localparam int unsigned LEAD_MAX_DEG  = 58;

	// debounce: hold time that swallows 3..6 us bounce
	localparam int unsigned DEB_NS     = 6000;
	localparam int unsigned DEB_CYC    = (DEB_NS + CLK_NS - 1) / CLK_NS;

	// predictor Hall frequency limits in millihertz
	localparam int unsigned R0_FMIN_MHZ = 800;
	localparam int unsigned R0_FMAX_MHZ = 80_000;
	localparam int unsigned R1_FMIN_MHZ = 400;
	localparam int unsigned R1_FMAX_MHZ = 40_000;
	localparam int unsigned R2_FMIN_MHZ = 3200;
	localparam int unsigned R2_FMAX_MHZ = 320_000;

	// longest period allowed: rounds down
	function automatic int unsigned hsd_per_floor(input int unsigned mhz);
		longint unsigned p;
		p = (64'(CLK_HZ) * 64'd1000) / 64'(mhz);
		return 32'(p);
	endfunction : hsd_per_floor

	// shortest period allowed: rounds up
	function automatic int unsigned hsd_per_ceil(input int unsigned mhz);
		longint unsigned p;
		p = (64'(CLK_HZ) * 64'd1000 + 64'(mhz) - 64'd1) / 64'(mhz);
		return 32'(p);
	endfunction : hsd_per_ceil

	typedef enum logic [1:0] {P_IDLE, P_RUN} hsd_pred_e;

endpackage : hsd_pkg

// ===== hdl/hsd_hall_if.sv
// hsd_hall_if: configuration into, and conditioned Hall state out of, the sensor stage
// assumes both ends run on pclk
`timescale 1ns/1ps
interface hsd_hall_if;
	logic [2:0] inv;
	logic       reg_en;
	logic [2:0] state;

	modport ctl  (output inv, output reg_en, input state);
	modport cond (input inv, input reg_en, output state);
endinterface : hsd_hall_if

// ===== hdl/hsd_hall_cond.sv
// hsd_hall_cond: Hall inversion, debounce and optional regulation
// assumes hall_raw is synchronous to pclk
`timescale 1ns/1ps
module hsd_hall_cond
	import hsd_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [2:0] hall_raw,
	hsd_hall_if.cond        h
);
	import hsd_pkg::*;

	localparam int unsigned CW = 10;
	if (DEB_CYC >= 2**CW || DEB_CYC < 2) begin : g_bad_deb
		$error("debounce count does not fit its counter");
	end

	localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

	logic [2:0]    inv_r;
	logic [2:0]    deb_r;
	logic [2:0]    held_r;
	logic [CW-1:0] cnt_r [3];

	function automatic logic one_step(input logic [2:0] a, input logic [2:0] b);
		logic [2:0] d;
		d = a ^ b;
		return (d == 3'h1) || (d == 3'h2) || (d == 3'h4);
	endfunction : one_step

	wire code_ok   = (deb_r != 3'h0) && (deb_r != 3'h7);
	wire held_ok   = (held_r != 3'h0) && (held_r != 3'h7);
	wire accept    = code_ok && (!held_ok || one_step(deb_r, held_r));

	// polarity fixed first so every later stage sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inv_r <= 3'h0;
		end else begin
			inv_r <= hall_raw ^ h.inv;
		end
	end

	// per input: new level taken only after it has stood DEB_CYC cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_r <= 3'h0;
			for (int i = 0; i < 3; i++) cnt_r[i] <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (inv_r[i] == deb_r[i]) begin
					cnt_r[i] <= '0;
				end else if (cnt_r[i] == DEB_LAST) begin
					cnt_r[i] <= '0;
					deb_r[i] <= inv_r[i];
				end else begin
					cnt_r[i] <= cnt_r[i] + CW'(1);
				end
			end
		end
	end

	// regulation drops illegal codes and jumps, holding the last good state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_r <= 3'h0;
		end else if (!h.reg_en || accept) begin
			held_r <= deb_r;
		end
	end

	assign h.state = held_r;

	a_inv_first: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (inv_r == $past(hall_raw ^ h.inv)))
		else $error("inversion stage does not follow raw input");

	a_deb_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(deb_r[0] != $past(deb_r[0])) |-> ($past(cnt_r[0]) == DEB_LAST))
		else $error("debounced input changed before hold time");

	a_reg_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(h.reg_en && !code_ok) |=> $stable(held_r))
		else $error("regulation let an illegal code through");

	a_reg_off: assert property (@(posedge pclk) disable iff (!presetn)
		!h.reg_en |=> (held_r == $past(deb_r)))
		else $error("unregulated state does not track debounce");

endmodule : hsd_hall_cond

// ===== testbench/hsd_sensor_model.sv
// hsd_sensor_model: three Hall sensors on a turning rotor, or a code held by the bench
// assumes run, per and code_in change just after rising pclk edges; push-pull sensor outputs
`timescale 1ns/1ps
module hsd_sensor_model (
	input  wire logic        pclk,
	input  wire logic        run,
	input  wire logic [15:0] per,
	input  wire logic [2:0]  code_in,
	output logic      [2:0]  hall
);
	// six-step Hall sequence, one step per sixth of a period
	localparam logic [17:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

	logic [15:0] cnt_r;
	logic [2:0]  step_r;
	wire         wrap_w;

	assign wrap_w = cnt_r >= per / 16'h6 - 16'h1;
	assign hall   = run ? SEQ[3 * step_r +: 3] : code_in;

	always_ff @(posedge pclk) begin
		if (!run || wrap_w) begin
			cnt_r <= 16'h0;
		end else begin
			cnt_r <= cnt_r + 16'h1;
		end
	end

	always_ff @(posedge pclk) begin
		if (!run) begin
			step_r <= 3'h0;
		end else if (wrap_w) begin
			step_r <= (step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
		end
	end
endmodule : hsd_sensor_model

// ===== testbench/test_hall_shift_drive_config.sv
// test_hall_shift_drive_config: registers, lead select, predictor ranges, drive mode, Hall conditioning
// assumes hsd_top with shortened predictor period limits and hsd_sensor_model on the Hall inputs
`timescale 1ns/1ps
module test_hall_shift_drive_config;
	import hsd_pkg::*;

	typedef struct {
		int         per;
		logic [1:0] rng;
		logic       lock;
	} hsd_row_s;

	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, run, sine_drive, predictor_locked, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] per;
	logic [2:0]  code_in, hall_raw;
	logic [4:0]  external_lead_pin, lead_code;
	logic [5:0]  lead_deg;
	int          errors = 0;
	int          checks = 0;
	logic [11:0] adr [3] = '{SHIFT_OFF, WAVE_OFF, SENSOR_OFF};
	logic [7:0]  msk [3] = '{8'hFF, 8'hC0, 8'h0F};
	hsd_row_s    rows [4] = '{'{6000, 2'h0, 1'b1}, '{4800, 2'h3, 1'b1}, '{4800, 2'h1, 1'b0}, '{12000, 2'h1, 1'b1}};

	always #4 pclk = ~pclk;

	hsd_top #(.PER_MIN0(5000), .PER_MAX0(7000), .PER_MIN2(4000), .PER_MAX2(6000)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hall_raw(hall_raw), .external_lead_pin(external_lead_pin), .lead_code(lead_code),
		.lead_deg(lead_deg), .sine_drive(sine_drive), .predictor_locked(predictor_locked)
	);

	hsd_sensor_model model_u (.pclk(pclk), .run(run), .per(per), .code_in(code_in), .hall(hall_raw));

	task automatic wrap_up;
		if (errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	// one APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q       = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd_hall(input logic [2:0] exp);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(q & 32'h7, {29'h0, exp});
	endtask : rd_hall

	task automatic drv(input logic [7:0] w, input logic exp);
		apb(1'b1, WAVE_OFF, {24'h0, w});
		wt(3);
		chk({31'h0, sine_drive}, {31'h0, exp});
	endtask : drv

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		run = 1'b0;
		per = 16'h0;
		code_in = 3'h1;
		external_lead_pin = 5'h0;
		wt(5);
		chk({17'h0, lead_code, lead_deg, sine_drive, predictor_locked, pready, pslverr}, 32'h0);
		wt(5);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, adr[i], 32'h0);
			chk(q, 32'h0);
			apb(1'b1, adr[i], 32'hFFFF_FFFF);
			apb(1'b0, adr[i], 32'h0);
			chk(q, {24'h0, msk[i]});
		end
		apb(1'b1, 12'h010, 32'h0000_00FF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		apb(1'b1, WAVE_OFF, 32'h0);
		apb(1'b1, SENSOR_OFF, 32'h0);
		for (int v = 0; v < 32; v++) begin
			external_lead_pin <= 5'(v);
			apb(1'b1, SHIFT_OFF, 32'(31 - v));
			wt(3);
			chk({27'h0, lead_code}, 32'(v));
			chk({26'h0, lead_deg}, 32'((v * 58 + 15) / 31));
			apb(1'b1, SHIFT_OFF, 32'(128 + 31 - v));
			wt(3);
			chk({27'h0, lead_code}, 32'(31 - v));
			chk({26'h0, lead_deg}, 32'(((31 - v) * 58 + 15) / 31));
		end
		run <= 1'b1;
		foreach (rows[i]) begin
			per <= 16'(rows[i].per);
			apb(1'b1, SHIFT_OFF, {25'h0, rows[i].rng, 5'h0});
			wt(rows[i].per * ((i > 0 && rows[i].per == rows[i > 0 ? i - 1 : 0].per) ? 1 : 2) + rows[i].per / 2 + 1500);
			chk({31'h0, predictor_locked}, {31'h0, rows[i].lock});
			chk({31'h0, sine_drive}, {31'h0, rows[i].lock});
		end
		drv(8'h80, 1'b0);
		drv(8'h40, 1'b1);
		// rotor stops; range 1x drops lock on the short periods from the inversion steps
		run <= 1'b0;
		apb(1'b1, WAVE_OFF, 32'h0);
		apb(1'b1, SHIFT_OFF, 32'h40);
		wt(800);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, SENSOR_OFF, 32'(i));
			wt(800);
			rd_hall(3'h1 ^ 3'(i));
		end
		apb(1'b1, SENSOR_OFF, 32'h0);
		wt(800);
		code_in <= 3'h3;
		wt(400);
		code_in <= 3'h1;
		wt(800);
		rd_hall(3'h1);
		code_in <= 3'h3;
		wt(500);
		rd_hall(3'h1);
		wt(400);
		rd_hall(3'h3);
		apb(1'b1, SENSOR_OFF, 32'h8);
		code_in <= 3'h0;
		wt(900);
		rd_hall(3'h3);
		apb(1'b1, SENSOR_OFF, 32'h0);
		wt(5);
		rd_hall(3'h0);
		chk({31'h0, predictor_locked}, 32'h0);
		drv(8'h40, 1'b0);
		drv(8'hC0, 1'b1);
		drv(8'h80, 1'b0);
		drv(8'h00, 1'b0);
		// reset in mid-run: outputs clear, bus usable at once
		presetn <= 1'b0;
		wt(2);
		chk({17'h0, lead_code, lead_deg, sine_drive, predictor_locked, pready, pslverr}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, SHIFT_OFF, 32'h0);
		chk(q, 32'h0);
		chk({27'h0, lead_code}, 32'h1F);
		wrap_up;
	end

	initial begin
		repeat (100000) @(posedge pclk);
		errors++;
		wrap_up;
	end
endmodule : test_hall_shift_drive_config
